// *** logic/conv_pkg.sv ***
package conv_pkg;
   // register offsets (byte bus, 8-bit data)
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] CFG_ADDR = 4'h1;
   localparam logic [3:0] CHAN_ADDR = 4'h2;
   localparam logic [3:0] RES_LO_ADDR = 4'h3;
   localparam logic [3:0] RES_HI_ADDR = 4'h4;
   localparam logic [3:0] WLO_LO_ADDR = 4'h5;
   localparam logic [3:0] WLO_HI_ADDR = 4'h6;
   localparam logic [3:0] WHI_LO_ADDR = 4'h7;
   localparam logic [3:0] WHI_HI_ADDR = 4'h8;
   localparam logic [3:0] STAT_ADDR = 4'h9;
   localparam logic [3:0] MASK_ADDR = 4'hA;
   // ctrl fields
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_SRC_LSB = 1;
   localparam int CTRL_LJUST_BIT = 3;
   localparam int CTRL_WIN_OUT_BIT = 4;
   localparam int CTRL_SHDN_BIT = 5;
   localparam int CTRL_BUSY_BIT = 7;
   // cfg fields
   localparam int CFG_GAIN_LSB = 0;
   localparam int CFG_REF_BIT = 3;
   localparam int CFG_DIFF_LSB = 4;
   // status bits
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_WIN_BIT = 1;
   localparam logic [7:0] CTRL_RESET = 8'h20;
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam logic [7:0] CHAN_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [11:0] WLO_RESET = 12'h000;
   localparam logic [11:0] WHI_RESET = 12'hFFF;
   localparam logic [3:0] CHAN_TEMP = 4'h8;
   localparam logic [2:0] GAIN_MAX = 3'h5;
   localparam int RES_W = 12;
   localparam int CONV_CYCLES = 16;
   localparam int CLK_HZ = 10_000_000;
   localparam int MIN_SAMPLE_NS = 10_000;
   localparam int SAMPLE_CYCLES = (MIN_SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [1:0] {
      SRC_SOFT = 2'b00,
      SRC_TMR2 = 2'b01,
      SRC_TMR3 = 2'b10,
      SRC_EXT = 2'b11
   } start_src_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } conv_state_t;
endpackage

// *** logic/conv_if.sv ***
`timescale 1ns/1ps
interface conv_if;
   logic start;
   logic done;
   logic [11:0] code;
   logic busy;
   modport ctl (output start, input done, input code, input busy);
   modport seq (input start, output done, output code, output busy);
endinterface

// *** logic/sar_sequencer.sv ***
`timescale 1ns/1ps
module sar_sequencer
   import conv_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [RES_W-1:0] analog_code,
   conv_if.seq cv
);
   logic [4:0] cnt_q;
   logic [RES_W-1:0] code_q;
   logic [RES_W-1:0] samp_q;
   conv_state_t st_q;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= ST_IDLE;
         cnt_q <= 5'h00;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (cv.start) begin
                  st_q <= ST_CONV;
                  cnt_q <= 5'h00;
               end
            end
            ST_CONV: begin
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'(CONV_CYCLES - 1)) begin
                  st_q <= ST_DONE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // one bit decided per cycle, msb first, against the held sample
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         samp_q <= 12'h000;
         code_q <= 12'h000;
      end else if (st_q == ST_IDLE && cv.start) begin
         samp_q <= analog_code;
         code_q <= 12'h000;
      end else if (st_q == ST_CONV && cnt_q < 5'(RES_W)) begin
         code_q[RES_W-1-cnt_q[3:0]] <= samp_q[RES_W-1-cnt_q[3:0]];
      end
   end

   assign cv.busy = (st_q != ST_IDLE);
   assign cv.done = (st_q == ST_DONE);
   assign cv.code = code_q;
endmodule // sar_sequencer

// *** logic/sar_adc_conversion_control.sv ***
`timescale 1ns/1ps
module sar_adc_conversion_control
   import conv_pkg::*;
#(
   parameter bit TEN_BIT = 1'b0
)(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic tmr2_ovf,
   input wire logic tmr3_ovf,
   input wire logic ext_start_pin,
   input wire logic [RES_W-1:0] analog_code,
   output logic [3:0] mux_sel,
   output logic [3:0] diff_pairs,
   output logic [2:0] gain_sel,
   output logic ref_sel_ext,
   output logic shutdown,
   output logic irq
);
   logic [7:0] ctrl_q;
   logic [7:0] cfg_q;
   logic [7:0] chan_q;
   logic [11:0] wlo_q;
   logic [11:0] whi_q;
   logic [15:0] res_q;
   logic [1:0] stat_q;
   logic [7:0] mask_q;
   logic [2:0] ext_sync_q;
   logic ext_level_q;
   logic ext_rise;
   logic trig;
   logic go_fire;
   logic [11:0] res_val;
   logic in_win;
   logic win_hit;
   start_src_t src;
   conv_if cv ();

   function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
      hit = (a == target);
   endfunction

   sar_sequencer u_seq (
      .clk(clk),
      .reset_n(reset_n),
      .analog_code(analog_code),
      .cv(cv)
   );

   // three stages; edge taken only once stages two and three agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ext_sync_q <= 3'h0;
         ext_level_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], ext_start_pin};
         if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_level_q <= ext_sync_q[2];
         end
      end
   end
   assign ext_rise = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_level_q;

   assign src = start_src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
   assign go_fire = wr && hit(addr, CTRL_ADDR) && wdata[CTRL_GO_BIT];

   always_comb begin
      case (src)
         SRC_SOFT: trig = go_fire;
         SRC_TMR2: trig = tmr2_ovf;
         SRC_TMR3: trig = tmr3_ovf;
         default: trig = ext_rise;
      endcase
   end

   // busy gates new starts; shutdown blocks them entirely
   assign cv.start = trig && !cv.busy && !ctrl_q[CTRL_SHDN_BIT];

   // ten-bit variant drops two lsbs
   assign res_val = TEN_BIT ? {2'b00, cv.code[11:2]} : cv.code;

   assign in_win = (res_val >= wlo_q) && (res_val <= whi_q);
   assign win_hit = ctrl_q[CTRL_WIN_OUT_BIT] ? !in_win : in_win;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RESET;
         cfg_q <= CFG_RESET;
         chan_q <= CHAN_RESET;
         wlo_q <= WLO_RESET;
         whi_q <= WHI_RESET;
         mask_q <= MASK_RESET;
      end else if (wr) begin
         if (hit(addr, CTRL_ADDR)) begin
            ctrl_q <= {1'b0, wdata[6:1], 1'b0};
         end else if (hit(addr, CFG_ADDR)) begin
            // gains above the top code clamp to GAIN_MAX (code 5)
            cfg_q <= {wdata[7:3], (wdata[2:0] > GAIN_MAX) ? GAIN_MAX : wdata[2:0]};
         end else if (hit(addr, CHAN_ADDR)) begin
            chan_q <= {4'h0, (wdata[3:0] > CHAN_TEMP) ? CHAN_TEMP : wdata[3:0]};
         end else if (hit(addr, WLO_LO_ADDR)) begin
            wlo_q[7:0] <= wdata;
         end else if (hit(addr, WLO_HI_ADDR)) begin
            wlo_q[11:8] <= wdata[3:0];
         end else if (hit(addr, WHI_LO_ADDR)) begin
            whi_q[7:0] <= wdata;
         end else if (hit(addr, WHI_HI_ADDR)) begin
            whi_q[11:8] <= wdata[3:0];
         end else if (hit(addr, MASK_ADDR)) begin
            mask_q <= {6'h00, wdata[1:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         res_q <= 16'h0000;
      end else if (cv.done) begin
         if (ctrl_q[CTRL_LJUST_BIT]) begin
            res_q <= TEN_BIT ? {res_val[9:0], 6'h00} : {res_val, 4'h0};
         end else begin
            res_q <= {4'h0, res_val};
         end
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stat_q <= 2'b00;
      end else begin
         stat_q[STAT_DONE_BIT] <= cv.done ||
            (stat_q[STAT_DONE_BIT] &&
             !(wr && hit(addr, STAT_ADDR) && wdata[STAT_DONE_BIT]));
         stat_q[STAT_WIN_BIT] <= (cv.done && win_hit) ||
            (stat_q[STAT_WIN_BIT] &&
             !(wr && hit(addr, STAT_ADDR) && wdata[STAT_WIN_BIT]));
      end
   end

   assign irq = |(stat_q & mask_q[1:0]);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (hit(addr, CTRL_ADDR)) begin
            rdata <= {cv.busy, ctrl_q[6:0]};
         end else if (hit(addr, CFG_ADDR)) begin
            rdata <= cfg_q;
         end else if (hit(addr, CHAN_ADDR)) begin
            rdata <= chan_q;
         end else if (hit(addr, RES_LO_ADDR)) begin
            rdata <= res_q[7:0];
         end else if (hit(addr, RES_HI_ADDR)) begin
            rdata <= res_q[15:8];
         end else if (hit(addr, WLO_LO_ADDR)) begin
            rdata <= wlo_q[7:0];
         end else if (hit(addr, WLO_HI_ADDR)) begin
            rdata <= {4'h0, wlo_q[11:8]};
         end else if (hit(addr, WHI_LO_ADDR)) begin
            rdata <= whi_q[7:0];
         end else if (hit(addr, WHI_HI_ADDR)) begin
            rdata <= {4'h0, whi_q[11:8]};
         end else if (hit(addr, STAT_ADDR)) begin
            rdata <= {6'h00, stat_q};
         end else if (hit(addr, MASK_ADDR)) begin
            rdata <= mask_q;
         end else begin
            rdata <= 8'h00;
         end
      end else begin
         rdata <= 8'h00;
      end
   end

   assign mux_sel = chan_q[3:0];
   assign diff_pairs = cfg_q[CFG_DIFF_LSB +: 4];
   assign gain_sel = cfg_q[CFG_GAIN_LSB +: 3];
   assign ref_sel_ext = cfg_q[CFG_REF_BIT];
   assign shutdown = ctrl_q[CTRL_SHDN_BIT];
endmodule // sar_adc_conversion_control

// *** dv/conv_checker.sv ***
`timescale 1ns/1ps
module conv_checker
   import conv_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [3:0] mux_sel,
   input wire logic [3:0] diff_pairs,
   input wire logic [2:0] gain_sel,
   input wire logic ref_sel_ext,
   input wire logic shutdown,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence cfg_wr;
      wr && addr == CFG_ADDR;
   endsequence
   sequence ctl_wr;
      wr && addr == CTRL_ADDR;
   endsequence
   rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata not idle");
   gain_lim_a: assert property (gain_sel <= GAIN_MAX)
      else $error("gain out of range");
   gain_wr_a: assert property (cfg_wr |=> gain_sel ==
      ($past(wdata[2:0]) > GAIN_MAX ? GAIN_MAX : $past(wdata[2:0]))) else $error("gain wrong");
   mux_wr_a: assert property (wr && addr == CHAN_ADDR |=> mux_sel ==
      ($past(wdata[3:0]) > CHAN_TEMP ? CHAN_TEMP : $past(wdata[3:0]))) else $error("mux wrong");
   diff_wr_a: assert property (cfg_wr |=> diff_pairs == $past(wdata[7:4]))
      else $error("pairs wrong");
   ref_wr_a: assert property (cfg_wr |=> ref_sel_ext == $past(wdata[3]))
      else $error("reference wrong");
   shdn_wr_a: assert property (ctl_wr |=> shutdown == $past(wdata[5]))
      else $error("shutdown wrong");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr) &&
      ($past(addr) == STAT_ADDR || $past(addr) == MASK_ADDR)) else $error("irq dropped");
endmodule // conv_checker

bind sar_adc_conversion_control conv_checker conv_checker_i (.clk, .reset_n, .addr, .wdata,
   .wr, .rd, .rdata, .mux_sel, .diff_pairs, .gain_sel, .ref_sel_ext, .shutdown, .irq);

// *** dv/trig_model.sv ***
`timescale 1ns/1ps
module trig_model (
   input wire logic clk,
   input wire logic fire,
   input wire logic [1:0] sel,
   output logic tmr2_ovf,
   output logic tmr3_ovf,
   output logic ext_start_pin
);
   int gap = 0;
   initial begin
      tmr2_ovf = 1'b0;
      tmr3_ovf = 1'b0;
      ext_start_pin = 1'b0;
   end
   // a fire inside the gap is dropped so starts stay at or below 100 ksps
   always @(posedge clk) begin
      tmr2_ovf <= fire && sel == 2'h1 && gap == 0;
      tmr3_ovf <= fire && sel == 2'h2 && gap == 0;
      ext_start_pin <= (fire && sel == 2'h3 && gap == 0) || (ext_start_pin && gap > 96);
      if (fire && gap == 0) gap <= 100;
      else if (gap > 0) gap <= gap - 1;
   end
endmodule // trig_model

// *** dv/sar_adc_conversion_control_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("MISMATCH %s exp %h got %h", n, e, g); end end
module sar_adc_conversion_control_tb_top;
   import conv_pkg::*;
   logic clk = 1'b0;
   logic reset_n, wr, rd, fire, ref_sel_ext, shutdown, irq, tmr2_ovf, tmr3_ovf, ext_start_pin;
   logic [3:0] addr, mux_sel, diff_pairs;
   logic [7:0] wdata, rdata, rdata10, s10;
   logic [1:0] sel;
   logic [2:0] gain_sel;
   logic [11:0] analog_code, c, lo, hi;
   logic [15:0] e, e10;
   logic lj, out;
   int err_count = 0;
   int checked = 0;
   always #50 clk = ~clk;
   sar_adc_conversion_control sar_adc_conversion_control_i (.clk, .reset_n, .addr, .wdata, .wr,
      .rd, .rdata, .tmr2_ovf, .tmr3_ovf, .ext_start_pin, .analog_code, .mux_sel, .diff_pairs,
      .gain_sel, .ref_sel_ext, .shutdown, .irq);
   // ten-bit variant shares every input; only its read port is compared
   sar_adc_conversion_control #(.TEN_BIT(1'b1)) sar_adc_conversion_control_ten_i (.clk,
      .reset_n, .addr, .wdata, .wr, .rd, .rdata(rdata10), .tmr2_ovf, .tmr3_ovf, .ext_start_pin,
      .analog_code, .mux_sel(), .diff_pairs(), .gain_sel(), .ref_sel_ext(), .shutdown(),
      .irq());
   trig_model trig_model_i (.clk, .fire, .sel, .tmr2_ovf, .tmr3_ovf, .ext_start_pin);
   task give_verdict;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wrt(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] x);
      logic [7:0] y;
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK("rdata", x, rdata)
      y = x;
      if (a == RES_LO_ADDR) y = e10[7:0];
      else if (a == RES_HI_ADDR) y = e10[15:8];
      else if (a == STAT_ADDR) y = s10;
      `CHK("rdata10", y, rdata10)
   endtask
   // bounded wait: a conversion that never ends must not hang the run
   task wait_irq;
      for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk) #1;
      if (irq !== 1'b1) begin
         err_count++;
         $display("MISMATCH irq_wait exp 1 got %b", irq);
      end
   endtask
   function automatic logic [15:0] just(input logic [11:0] v, input logic l);
      return l ? {v, 4'h0} : {4'h0, v};
   endfunction
   initial begin
      reset_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      fire = 1'b0;
      sel = 2'h0;
      analog_code = 12'h000;
      e10 = 16'h0000;
      s10 = 8'h00;
      void'($urandom(32'hD50EDBD5));
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rdc(CTRL_ADDR, CTRL_RESET);
      rdc(CFG_ADDR, CFG_RESET);
      rdc(4'hF, 8'h00);
      wrt(CFG_ADDR, 8'hAF);
      wrt(CHAN_ADDR, 8'h0F);
      rdc(CFG_ADDR, 8'hAD);
      rdc(CHAN_ADDR, 8'h08);
      `CHK("gain", 3'h5, gain_sel)
      `CHK("ref", 1'b1, ref_sel_ext)
      `CHK("pairs", 4'hA, diff_pairs)
      `CHK("mux", 4'h8, mux_sel)
      $display("registers done");
      wrt(MASK_ADDR, 8'h01);
      // shutdown and source act from the stored value, so leave shutdown first
      wrt(CTRL_ADDR, 8'h00);
      for (int k = 0; k < 8; k++) begin
         c = k ? 12'($urandom) : 12'hFFF;
         hi = k ? 12'($urandom) : 12'hFFF;
         lo = 12'($urandom);
         lj = 1'($urandom);
         out = 1'($urandom);
         wrt(WLO_LO_ADDR, lo[7:0]);
         wrt(WLO_HI_ADDR, {4'h0, lo[11:8]});
         wrt(WHI_LO_ADDR, hi[7:0]);
         wrt(WHI_HI_ADDR, {4'h0, hi[11:8]});
         analog_code <= c;
         wrt(CTRL_ADDR, {3'h0, out, lj, 3'h1});
         wait_irq;
         e = just(c, lj);
         e10 = lj ? {c[11:2], 6'h00} : {6'h00, c[11:2]};
         s10 = {6'h00, ({2'b00, c[11:2]} >= lo && {2'b00, c[11:2]} <= hi) ^ out, 1'b1};
         rdc(RES_LO_ADDR, e[7:0]);
         rdc(RES_HI_ADDR, e[15:8]);
         rdc(STAT_ADDR, {6'h00, (c >= lo && c <= hi) ^ out, 1'b1});
         wrt(STAT_ADDR, 8'h03);
      end
      $display("conversions done");
      for (int s = 1; s < 4; s++) begin
         wrt(CTRL_ADDR, {5'h00, s[1:0], 1'b0});
         repeat (100) @(posedge clk);
         fire <= 1'b1;
         sel <= s[1:0];
         @(posedge clk);
         fire <= 1'b0;
         wait_irq;
         `CHK("irq", 1'b1, irq)
         wrt(STAT_ADDR, 8'h03);
      end
      $display("triggers done");
      wrt(MASK_ADDR, 8'h00);
      analog_code <= 12'h5A5;
      e10 = 16'h0169;
      wrt(CTRL_ADDR, 8'h00);
      wrt(CTRL_ADDR, 8'h01);
      analog_code <= 12'h123;
      repeat (4) @(posedge clk);
      wrt(CTRL_ADDR, 8'h01);
      repeat (30) @(posedge clk) #1;
      `CHK("irq", 1'b0, irq)
      rdc(RES_LO_ADDR, 8'hA5);
      wrt(MASK_ADDR, 8'h01);
      #1;
      `CHK("irq", 1'b1, irq)
      wrt(STAT_ADDR, 8'h03);
      wrt(CTRL_ADDR, 8'h20);
      wrt(CTRL_ADDR, 8'h21);
      repeat (30) @(posedge clk) #1;
      `CHK("irq", 1'b0, irq)
      `CHK("shdn", 1'b1, shutdown)
      $display("busy and shutdown done");
      give_verdict;
   end
endmodule // sar_adc_conversion_control_tb_top
